// ### src/flr_device.sv
// Device end: power modes, power-on reset, warm reset on the shared pin and
// the command decode that steers deep sleep and software reset.
// Assumes the host keeps its own timing duties; link pins are asynchronous.
`timescale 1ns/1ps
`include "flr_cfg.svh"
// Summary of operation
// - Select low means enabled, active power.
// - After deselect stay active while busy, then standby.
// - Deep sleep command enters deep sleep mode.
// - Deep sleep accepted only with write flag clear.
// - In deep sleep only release command works.
// - Host waits power-up time before selecting.
// - Pin is reset after deselect time or quad off.
// - Reset input ignored during power-on sequence.
// - Reset low at power-up end holds reset.
// - Host holds select high for reset hold.
// - Host keeps reset high setup time first.
// - Pin ignored in deselect window; data when selected.
// - Shared pin weakly pulled high inside.
// - Long low pulse restores registers, warm recovery.
// - Failed power-on makes reset rerun full sequence.
// - Warm reset aborts, tristates, ignores commands.
// - Software reset works whatever the pin state.
// - After quad read, drive line three high.
// - Host drives line three high after quad writes.
// - Quad off, host raises select during recovery.
// - Host low width plus hold covers recovery.
module flr_device #(
  parameter logic [15:0] PU_CYC = 16'(`FLR_CYC_MIN(`FLR_T_PU_NS)),
  parameter logic [15:0] DESEL_CYC = 16'(`FLR_CYC_MIN(`FLR_T_CS_NS)),
  parameter logic [15:0] RP_CYC = 16'(`FLR_CYC_MIN(`FLR_T_RP_NS)),
  parameter logic [15:0] RPH_CYC = 16'(`FLR_CYC_MAX(`FLR_T_RPH_NS)),
  parameter logic [15:0] RES_CYC = 16'(`FLR_CYC_MAX(`FLR_T_RES_NS))
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  flr_link_if.dev link,
  input wire logic [7:0] status_reg1_volatile_in,
  input wire logic [7:0] config_reg1_volatile_in,
  input wire logic por_fault_in,
  output flr_pkg::flr_power_e power_mode_out,
  output logic in_reset_out,
  output logic abort_out,
  output logic restore_out,
  output logic [7:0] cmd_byte_out,
  output logic cmd_strobe_out
);
  typedef enum logic [2:0] {
    DEV_POR,
    DEV_HELD,
    DEV_IDLE,
    DEV_DEEP,
    DEV_RELEASE,
    DEV_WARM
  } flr_dev_state_e;

  typedef struct packed {
    flr_dev_state_e st;
    logic [15:0] desel;
    logic [15:0] tmr;
    logic [15:0] rp;
    logic [7:0] sh;
    logic [3:0] bits;
    logic sclk_d;
    logic cs_d;
    logic drive_hi;
    logic por_bad;
    logic abort;
    logic restore;
    logic strobe;
    logic [7:0] byte_q;
    logic in_rst;
    flr_pkg::flr_power_e mode;
  } flr_dev_s;

  flr_dev_s st_reg;
  flr_dev_s st_next;
  logic [3:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic si_s;
  logic io3_s;
  logic write_in_progress_flag;
  logic quad_en;
  logic sclk_rise;
  logic cs_rise;
  logic armed;
  logic rst_low;
  logic byte_done;
  logic trigger;

  // All link pins come from another domain, so each passes the filter.
  flr_sync #(
    .W(4),
    .RST_VAL(`FLR_SYNC_RST)
  ) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .async_in({link.cs_n, link.sclk, link.si, link.io3}),
    .sync_out(pins_s)
  );

  assign cs_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign si_s = pins_s[1];
  assign io3_s = pins_s[0];
  assign write_in_progress_flag = status_reg1_volatile_in[`FLR_WIP_BIT];
  assign quad_en = config_reg1_volatile_in[`FLR_QUAD_BIT];

  // Edge detection and the conditions that qualify the shared pin as reset.
  always_comb begin
    sclk_rise = sclk_s & ~st_reg.sclk_d;
    cs_rise = cs_s & ~st_reg.cs_d;
    // Quad off makes the pin a reset even with select low.
    armed = (cs_s && (st_reg.desel == DESEL_CYC)) || !quad_en;
    rst_low = armed && !io3_s;
    byte_done = cs_rise && (st_reg.bits == `FLR_CMD_BITS);
    // A low pulse counts only once the power-on sequence is over.
    trigger = rst_low && (st_reg.rp == RP_CYC - 16'h0001);
  end

  // Next-state logic for the whole device end.
  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = sclk_s;
    st_next.cs_d = cs_s;
    st_next.abort = 1'b0;
    st_next.restore = 1'b0;
    st_next.strobe = 1'b0;

    // Deselect window counter saturates at its terminal count.
    if (!cs_s) begin
      st_next.desel = 16'h0000;
    end else if (st_reg.desel != DESEL_CYC) begin
      st_next.desel = st_reg.desel + 16'h0001;
    end

    // Low-pulse width counter; it restarts whenever the pin is not a low reset.
    if (rst_low && (st_reg.st != DEV_POR) && (st_reg.st != DEV_HELD)) begin
      if (st_reg.rp != RP_CYC) begin
        st_next.rp = st_reg.rp + 16'h0001;
      end
    end else begin
      st_next.rp = 16'h0000;
    end

    // Serial shifter: MSB first on rising serial clock while selected.
    if (cs_s) begin
      st_next.bits = 4'h0;
    end else if (sclk_rise && (st_reg.bits != `FLR_CMD_BITS)) begin
      st_next.sh = {st_reg.sh[6:0], si_s};
      st_next.bits = st_reg.bits + 4'h1;
    end
    if (byte_done) begin
      st_next.byte_q = st_reg.sh;
      // In deep sleep only the release opcode counts as taken.
      st_next.strobe = (st_reg.st == DEV_IDLE) ||
        ((st_reg.st == DEV_DEEP) && (st_reg.sh == `FLR_OP_RELEASE));
    end

    // Hold line three high through the window after a quad read.
    if (cs_rise) begin
      st_next.drive_hi = byte_done && (st_reg.sh == `FLR_OP_QUAD_READ) &&
        (st_reg.st == DEV_IDLE);
    end else if (!cs_s || (st_reg.desel == DESEL_CYC)) begin
      st_next.drive_hi = 1'b0;
    end

    unique case (st_reg.st)
      DEV_POR: begin
        // The full power-on sequence ignores the pin until it ends.
        st_next.por_bad = st_reg.por_bad | por_fault_in;
        st_next.tmr = st_reg.tmr + 16'h0001;
        if (st_reg.tmr == PU_CYC - 16'h0001) begin
          st_next.tmr = 16'h0000;
          st_next.restore = 1'b1;
          // A pin still low at the end keeps the device in reset.
          st_next.st = io3_s ? DEV_IDLE : DEV_HELD;
        end
      end
      DEV_HELD: begin
        if (io3_s) begin
          st_next.st = DEV_IDLE;
        end
      end
      DEV_IDLE: begin
        if (byte_done && (st_reg.sh == `FLR_OP_DEEP) && !write_in_progress_flag) begin
          st_next.st = DEV_DEEP;
        end else if (byte_done && (st_reg.sh == `FLR_OP_SWRESET)) begin
          // Software reset does not look at the shared pin.
          st_next.st = DEV_WARM;
          st_next.abort = 1'b1;
          st_next.tmr = 16'h0000;
        end
      end
      DEV_DEEP: begin
        // Every other opcode is dropped here.
        if (byte_done && (st_reg.sh == `FLR_OP_RELEASE)) begin
          st_next.st = DEV_RELEASE;
          st_next.tmr = 16'h0000;
        end
      end
      DEV_RELEASE: begin
        st_next.tmr = st_reg.tmr + 16'h0001;
        if (st_reg.tmr == RES_CYC - 16'h0001) begin
          st_next.st = DEV_IDLE;
        end
      end
      DEV_WARM: begin
        // Commands are ignored and outputs released until recovery ends.
        st_next.drive_hi = 1'b0;
        st_next.tmr = st_reg.tmr + 16'h0001;
        if (st_reg.tmr == RPH_CYC - 16'h0001) begin
          st_next.st = DEV_IDLE;
          st_next.restore = 1'b1;
        end
      end
    endcase

    // A qualified low pulse wins over any mode outside reset.
    if (trigger && (st_reg.st != DEV_WARM)) begin
      st_next.tmr = 16'h0000;
      st_next.drive_hi = 1'b0;
      if (st_reg.por_bad) begin
        // A failed power-on is repaired only by the full sequence.
        st_next.st = DEV_POR;
        st_next.por_bad = 1'b0;
      end else begin
        st_next.st = DEV_WARM;
        st_next.abort = 1'b1;
      end
    end

    // Power mode and reset flag follow the next state.
    st_next.in_rst = (st_next.st == DEV_POR) || (st_next.st == DEV_HELD) ||
      (st_next.st == DEV_WARM);
    if (st_next.in_rst) begin
      st_next.mode = flr_pkg::FLR_PWR_RESET;
    end else if (st_next.st == DEV_DEEP) begin
      st_next.mode = flr_pkg::FLR_PWR_DEEP;
    end else if (!cs_s || write_in_progress_flag || (st_next.st == DEV_RELEASE)) begin
      st_next.mode = flr_pkg::FLR_PWR_ACTIVE;
    end else begin
      st_next.mode = flr_pkg::FLR_PWR_STANDBY;
    end
  end

  // State register; reset starts the power-on sequence.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= '{st: DEV_POR, sclk_d: 1'b0, cs_d: 1'b1,
        mode: flr_pkg::FLR_PWR_RESET, in_rst: 1'b1, default: '0};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // The device only ever drives line three high, so a float reads the same.
  assign link.io3_dev_o = 1'b1;
  assign link.io3_dev_oe = st_reg.drive_hi;
  assign power_mode_out = st_reg.mode;
  assign in_reset_out = st_reg.in_rst;
  assign abort_out = st_reg.abort;
  assign restore_out = st_reg.restore;
  assign cmd_byte_out = st_reg.byte_q;
  assign cmd_strobe_out = st_reg.strobe;
endmodule : flr_device

// ### shared/flr_cfg.svh
// Timing, opcode and bit-position constants for the flash reset and power block.
// Assumes a 10 MHz system clock on both ends; included by its bare name.
`ifndef FLR_CFG_SVH
`define FLR_CFG_SVH

// System clock period in ns.
`define FLR_CLK_NS 100
// A least time rounds up and a longest time rounds down, neither below one cycle.
`define FLR_CYC_MIN(t_ns) ((((t_ns) + `FLR_CLK_NS - 1) / `FLR_CLK_NS) < 1 ? 1 : \
  (((t_ns) + `FLR_CLK_NS - 1) / `FLR_CLK_NS))
`define FLR_CYC_MAX(t_ns) (((t_ns) / `FLR_CLK_NS) < 1 ? 1 : ((t_ns) / `FLR_CLK_NS))

// Times in ns.
`define FLR_T_PU_NS 300000
`define FLR_T_CS_NS 50
`define FLR_T_RP_NS 200
`define FLR_T_RPH_NS 35000
`define FLR_T_RH_NS 50
`define FLR_T_RS_NS 50
`define FLR_T_RES_NS 30000

// Extra cycles the host adds to cover the device's input synchroniser.
`define FLR_SYNC_MARGIN 16'h0004

// Command opcodes.
`define FLR_OP_DEEP 8'hb9
`define FLR_OP_RELEASE 8'hab
`define FLR_OP_SWRESET 8'hf0
`define FLR_OP_QUAD_READ 8'heb

// Bit positions in the volatile status and configuration bytes.
`define FLR_WIP_BIT 0
`define FLR_QUAD_BIT 1

// Command length and synchroniser reset image {select_n, sclk, si, io3}.
`define FLR_CMD_BITS 4'h8
`define FLR_SYNC_RST 4'h9

`endif

// ### shared/flr_pkg.sv
// Types shared by both ends of the flash reset and power link.
// Assumes nothing beyond a SystemVerilog compiler.
package flr_pkg;

  // Power mode reported by the device end.
  typedef enum logic [2:0] {
    FLR_PWR_RESET,
    FLR_PWR_ACTIVE,
    FLR_PWR_STANDBY,
    FLR_PWR_DEEP
  } flr_power_e;

endpackage : flr_pkg

// ### shared/flr_link_if.sv
// Link between the host controller and the flash device end.
// Assumes the testbench connects both modports; io3 is resolved here.
`timescale 1ns/1ps
interface flr_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic io3_host_o;
  logic io3_host_oe;
  logic io3_dev_o;
  logic io3_dev_oe;
  logic io3;

  // Undriven, the shared pin floats to high through the device's weak pull-up.
  assign io3 = io3_host_oe ? io3_host_o : (io3_dev_oe ? io3_dev_o : 1'b1);

  modport host (
    output cs_n,
    output sclk,
    output si,
    output io3_host_o,
    output io3_host_oe,
    input io3
  );
  modport dev (
    input cs_n,
    input sclk,
    input si,
    output io3_dev_o,
    output io3_dev_oe,
    input io3
  );
endinterface : flr_link_if

// ### src/flr_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
module flr_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } flr_sync_s;

  flr_sync_s st_reg;
  flr_sync_s st_next;

  // Stage one feeds only stage two, so no logic sees a metastable value.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.q;
endmodule : flr_sync

// ### src/flr_host.sv
// Host end: sends one-byte commands and hardware reset pulses on the link.
// Assumes a 10 MHz clock; makes the serial clock itself by division.
`timescale 1ns/1ps
`include "flr_cfg.svh"
module flr_host #(
  parameter logic [15:0] DIV = 16'h0004,
  parameter logic [15:0] PU_CYC = 16'(`FLR_CYC_MIN(`FLR_T_PU_NS)),
  parameter logic [15:0] DESEL_CYC = 16'(`FLR_CYC_MIN(`FLR_T_CS_NS)),
  parameter logic [15:0] RPH_CYC = 16'(`FLR_CYC_MIN(`FLR_T_RPH_NS)),
  parameter logic [15:0] HOLD_CYC = 16'(`FLR_CYC_MIN(`FLR_T_RH_NS + `FLR_T_RS_NS))
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  flr_link_if.host link,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_op_in,
  input wire logic cmd_quad_write_in,
  input wire logic hw_reset_in,
  output logic ready_out
);
  typedef enum logic [2:0] {
    HST_POR,
    HST_IDLE,
    HST_SEL,
    HST_SHIFT,
    HST_DESEL,
    HST_RST_LOW,
    HST_RST_HOLD
  } flr_host_state_e;

  typedef struct packed {
    flr_host_state_e st;
    logic [15:0] cnt;
    logic [7:0] sh;
    logic [3:0] bits;
    logic quad_wr;
    logic cs_n;
    logic sclk;
    logic io3_o;
    logic io3_oe;
  } flr_host_s;

  flr_host_s st_reg;
  flr_host_s st_next;

  // Next-state logic; the counter is reused for each timed phase.
  always_comb begin
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + 16'h0001;
    unique case (st_reg.st)
      HST_POR: begin
        // Stay deselected until power-up time plus the sync margin.
        if (st_reg.cnt == PU_CYC + `FLR_SYNC_MARGIN) begin
          st_next.st = HST_IDLE;
        end
      end
      HST_IDLE: begin
        st_next.cnt = 16'h0000;
        if (hw_reset_in) begin
          // Reset is pulled only with select high, so recovery never overlaps it.
          st_next.st = HST_RST_LOW;
          st_next.io3_oe = 1'b1;
          st_next.io3_o = 1'b0;
        end else if (cmd_valid_in) begin
          st_next.st = HST_SEL;
          st_next.cs_n = 1'b0;
          st_next.sh = cmd_op_in;
          st_next.quad_wr = cmd_quad_write_in;
          st_next.bits = 4'h0;
        end
      end
      HST_SEL: begin
        if (st_reg.cnt == DIV - 16'h0001) begin
          st_next.st = HST_SHIFT;
          st_next.cnt = 16'h0000;
        end
      end
      HST_SHIFT: begin
        if (st_reg.cnt == DIV - 16'h0001) begin
          st_next.cnt = 16'h0000;
          st_next.sclk = ~st_reg.sclk;
          if (!st_reg.sclk) begin
            st_next.bits = st_reg.bits + 4'h1;
          end else if (st_reg.bits == `FLR_CMD_BITS) begin
            st_next.st = HST_DESEL;
            st_next.cs_n = 1'b1;
            // After a quad write the host holds line three high.
            st_next.io3_oe = st_reg.quad_wr;
            st_next.io3_o = 1'b1;
          end else begin
            st_next.sh = {st_reg.sh[6:0], 1'b0};
          end
        end
      end
      HST_DESEL: begin
        if (st_reg.cnt == DESEL_CYC + `FLR_SYNC_MARGIN) begin
          st_next.st = HST_IDLE;
          st_next.io3_oe = 1'b0;
        end
      end
      HST_RST_LOW: begin
        // Low width alone covers recovery, so low plus hold does too.
        if (st_reg.cnt == RPH_CYC + `FLR_SYNC_MARGIN) begin
          st_next.st = HST_RST_HOLD;
          st_next.io3_oe = 1'b0;
          st_next.cnt = 16'h0000;
        end
      end
      HST_RST_HOLD: begin
        // Select stays high and reset high before anything new.
        if (st_reg.cnt == HOLD_CYC + `FLR_SYNC_MARGIN) begin
          st_next.st = HST_IDLE;
        end
      end
    endcase
  end

  // State register; pins idle with select high and line three released.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= '{st: HST_POR, cs_n: 1'b1, io3_o: 1'b1, default: '0};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign ready_out = (st_reg.st == HST_IDLE);
  assign link.cs_n = st_reg.cs_n;
  assign link.sclk = st_reg.sclk;
  assign link.si = st_reg.sh[7];
  assign link.io3_host_o = st_reg.io3_o;
  assign link.io3_host_oe = st_reg.io3_oe;
endmodule : flr_host

// ### verification/flr_asserts.sv
// Checker for the flash reset link: host pin duties and device drive of the shared pin.
// Assumes the bench instantiates it beside the link interface, fed by name.
`timescale 1ns/1ps
module flr_asserts #(
  parameter logic [15:0] PU_CYC = 16'h0014,
  parameter logic [15:0] RPH_CYC = 16'h0014
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic io3_host_o,
  input wire logic io3_host_oe,
  input wire logic io3_dev_o,
  input wire logic io3_dev_oe,
  input wire logic io3
);
  logic host_rst;
  logic [15:0] por_cnt_reg;
  logic [15:0] low_cnt_reg;

  // The host pulls the pin low only when it means a hardware reset.
  assign host_rst = io3_host_oe & ~io3_host_o;

  // Cycles since release, saturating, and the length of the current host low pulse.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      por_cnt_reg <= 16'h0000;
      low_cnt_reg <= 16'h0000;
    end else begin
      if (por_cnt_reg != 16'hffff) begin
        por_cnt_reg <= por_cnt_reg + 16'h0001;
      end
      low_cnt_reg <= host_rst ? low_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_por_quiet_select: assert property (por_cnt_reg < PU_CYC |-> cs_n)
    else $error("select went low during power-up");
  a_dev_drive_high: assert property (io3_dev_oe |-> io3_dev_o && io3)
    else $error("shared pin not high while the device drives it");
  a_dev_only_deselected: assert property (io3_dev_oe |-> cs_n)
    else $error("device drove the shared pin while selected");
  a_dev_drive_bounded: assert property ($rose(io3_dev_oe) |-> ##[1:8] !io3_dev_oe)
    else $error("device kept driving the shared pin too long");
  a_dev_after_deselect: assert property ($rose(io3_dev_oe) |-> cs_n && $past(cs_n, 2))
    else $error("device drive did not follow a deselect");
  a_rst_pulse_cover: assert property ($fell(host_rst) |-> low_cnt_reg >= RPH_CYC)
    else $error("host reset pulse shorter than recovery");
  a_rst_pulse_min: assert property ($rose(host_rst) |-> host_rst [*3])
    else $error("host reset pulse too short");
  a_rst_deselected: assert property (host_rst |-> cs_n)
    else $error("select low during host reset");
  a_rst_hold_select: assert property ($fell(host_rst) |-> cs_n [*2])
    else $error("select low too soon after reset");
  a_rst_setup_high: assert property ($fell(host_rst) |-> !host_rst [*2])
    else $error("reset pin low again too soon");
endmodule : flr_asserts

// ### verification/flash_reset_and_power_modes_tb.sv
// Testbench joining the host and device ends over the link interface.
// Assumes shortened power-up and recovery counts; clock 10 MHz.
`timescale 1ns/1ps
module flash_reset_and_power_modes_tb;
  localparam logic [15:0] PU = 16'h0028;
  localparam logic [15:0] RPH = 16'h0014;
  localparam logic [15:0] RES = 16'h0014;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] status_in = 8'h00;
  logic [7:0] config_in = 8'h00;
  logic por_fault_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [7:0] cmd_op_in = 8'h00;
  logic cmd_quad_write_in = 1'b0;
  logic hw_reset_in = 1'b0;
  logic ready_out;
  flr_pkg::flr_power_e power_mode_out;
  logic in_reset_out, abort_out, restore_out, cmd_strobe_out;
  logic [7:0] cmd_byte_out;
  int err_count = 0;
  int n_tests = 0;
  int n_strobe = 0;
  int n_abort = 0;
  int n_restore = 0;
  int n_dev_oe = 0;
  int n_host_hi = 0;

  flr_link_if link_if();
  flr_host #(.PU_CYC(PU), .RPH_CYC(RPH + 16'h0004)) flr_host_inst (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .ce_in(1'b1), .link(link_if.host), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in), .cmd_quad_write_in(cmd_quad_write_in), .hw_reset_in(hw_reset_in),
    .ready_out(ready_out));
  flr_device #(.PU_CYC(PU), .RPH_CYC(RPH), .RES_CYC(RES)) flr_device_inst (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .ce_in(1'b1), .link(link_if.dev), .status_reg1_volatile_in(status_in),
    .config_reg1_volatile_in(config_in), .por_fault_in(por_fault_in),
    .power_mode_out(power_mode_out), .in_reset_out(in_reset_out), .abort_out(abort_out),
    .restore_out(restore_out), .cmd_byte_out(cmd_byte_out), .cmd_strobe_out(cmd_strobe_out));
  flr_asserts #(.PU_CYC(PU), .RPH_CYC(RPH)) flr_asserts_inst (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .cs_n(link_if.cs_n), .sclk(link_if.sclk), .si(link_if.si),
    .io3_host_o(link_if.io3_host_o), .io3_host_oe(link_if.io3_host_oe),
    .io3_dev_o(link_if.io3_dev_o), .io3_dev_oe(link_if.io3_dev_oe), .io3(link_if.io3));

  // Half-period toggle gives the 100 ns system clock.
  always #50 clk_in = ~clk_in;

  // Pulses are counted here so a one-cycle output is never missed by the sequence.
  always @(posedge clk_in) begin
    if (cmd_strobe_out === 1'b1) n_strobe++;
    if (abort_out === 1'b1) n_abort++;
    if (restore_out === 1'b1) n_restore++;
    if (link_if.io3_dev_oe === 1'b1) n_dev_oe++;
    if (link_if.io3_host_oe === 1'b1 && link_if.io3_host_o === 1'b1) n_host_hi++;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic expire();
    err_count++;
    $display("CHECK FAILED at %0t: wait expired, seen %h expected %h", $time, 1'b0, 1'b1);
    report_and_stop();
  endtask : expire

  // Inputs always change 1 ns after the rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic wait_ready();
    int i;
    for (i = 0; i < 400 && ready_out !== 1'b1; i++) tick(1);
    if (ready_out !== 1'b1) expire();
  endtask : wait_ready

  task automatic wait_reset(input logic lvl, output int cyc);
    for (cyc = 0; cyc < 400 && in_reset_out !== lvl; cyc++) tick(1);
    if (in_reset_out !== lvl) expire();
  endtask : wait_reset

  task automatic wait_mode(input flr_pkg::flr_power_e m);
    int i;
    for (i = 0; i < 400 && power_mode_out !== m; i++) tick(1);
    check(16'(power_mode_out), 16'(m));
  endtask : wait_mode

  // One command byte; the mode is sampled in the first bit of the frame, after the select syncs in.
  task automatic send(input logic [7:0] op, input logic qw, input logic chk);
    wait_ready();
    cmd_op_in = op;
    cmd_quad_write_in = qw;
    cmd_valid_in = 1'b1;
    tick(1);
    cmd_valid_in = 1'b0;
    tick(8);
    if (chk) check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_ACTIVE));
    wait_ready();
    tick(8);
  endtask : send

  // Host reset pulse; returns cycles the device spent in reset afterwards.
  task automatic pulse(output int cyc);
    int c;
    wait_ready();
    hw_reset_in = 1'b1;
    tick(1);
    hw_reset_in = 1'b0;
    wait_reset(1'b1, c);
    wait_reset(1'b0, cyc);
    wait_ready();
  endtask : pulse

  initial begin
    int c, a, r, s, d;
    tick(2);
    rst_b_in = 1'b1;
    check(16'(in_reset_out), 16'h0001);
    wait_reset(1'b0, c);
    check(16'(c >= int'(PU)), 16'h0001);
    // The restore pulse stands in the same cycle as the mode change; let it be counted.
    tick(1);
    check(16'(n_restore), 16'h0001);
    check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_STANDBY));
    $display("test power-up done");
    status_in = 8'h01;
    send(8'h05, 1'b0, 1'b1);
    check(16'(n_strobe), 16'h0001);
    check(16'(cmd_byte_out), 16'h0005);
    check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_ACTIVE));
    send(8'hb9, 1'b0, 1'b1);
    check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_ACTIVE));
    status_in = 8'h00;
    wait_mode(flr_pkg::FLR_PWR_STANDBY);
    $display("test active and standby done");
    send(8'hb9, 1'b0, 1'b1);
    check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_DEEP));
    s = n_strobe;
    send(8'hf0, 1'b0, 1'b0);
    check(16'(n_strobe - s), 16'h0000);
    check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_DEEP));
    send(8'hab, 1'b0, 1'b0);
    check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_ACTIVE));
    wait_mode(flr_pkg::FLR_PWR_STANDBY);
    $display("test deep sleep done");
    config_in = 8'h02;
    a = n_abort;
    d = n_dev_oe;
    send(8'heb, 1'b0, 1'b1);
    check(16'(n_dev_oe > d), 16'h0001);
    d = n_host_hi;
    send(8'h05, 1'b1, 1'b1);
    check(16'(n_host_hi > d), 16'h0001);
    check(16'(n_abort - a), 16'h0000);
    $display("test quad deselect done");
    // Warm reset with quad off, then with quad on; quad off arms the pin even when selected, quad on only once deselected.
    for (int k = 0; k < 2; k++) begin
      config_in = (k == 0) ? 8'h00 : 8'h02;
      a = n_abort;
      r = n_restore;
      pulse(c);
      check(16'(n_abort - a), 16'h0001);
      check(16'(c + 1 >= int'(RPH) && c <= int'(RPH) + 1), 16'h0001);
      check(16'(n_restore - r), 16'h0001);
      check(16'(power_mode_out), 16'(flr_pkg::FLR_PWR_STANDBY));
    end
    $display("test warm reset done");
    a = n_abort;
    r = n_restore;
    send(8'hf0, 1'b0, 1'b1);
    check(16'(n_abort - a), 16'h0001);
    wait_reset(1'b0, c);
    tick(1);
    check(16'(n_restore - r), 16'h0001);
    $display("test software reset done");
    // A faulty power-up makes the next pulse rerun the full power-up count.
    por_fault_in = 1'b1;
    rst_b_in = 1'b0;
    tick(2);
    rst_b_in = 1'b1;
    wait_reset(1'b0, c);
    por_fault_in = 1'b0;
    pulse(c);
    check(16'(c + 2 >= int'(PU)), 16'h0001);
    $display("test failed power-up done");
    report_and_stop();
  end
endmodule : flash_reset_and_power_modes_tb
